// ### logic/pss_regs.svh
// How it works
// - Clock split into four phases per instruction.
// - PC advances at phase one, fetch there.
// - Fetch of next overlaps current execute.
// - Jump or call costs two cycles, flush.
// - True skip discards prefetch, inserts dummy cycle.
// - Twelve bit PC, only low byte visible.
// - PC increments except on control transfers.
// - Jump, call, interrupt, reset load full address.
// - Low byte write jumps within page, dummy.
// - Software reads and writes PC low byte.
// - Eight level stack, not software visible.
// - Stack pointer is internal and hidden.
// - Call or interrupt acknowledge pushes PC.
// - Return instructions pop saved PC.
// - Reset leaves stack pointer at empty top.
// - Full stack withholds interrupt acknowledge until return.
// - Call still executes when stack full.
// - Overflow drops oldest saved PC value.
// - Reset loads PC zero, fetch starts there.
`ifndef PSS_REGS_SVH
`define PSS_REGS_SVH

// ---------------------------------------------------------------
// Sizes and reset values.
// ---------------------------------------------------------------
`define PSS_PC_W        12
`define PSS_STACK_DEPTH 8
`define PSS_RESET_PC    12'h000
`define PSS_INT_VECTOR  12'h004
`define PSS_PAGE_W      8

// ---------------------------------------------------------------
// Register byte offsets and fields.
// ---------------------------------------------------------------
`define PSS_REG_PCL     4'h0
`define PSS_REG_STAT    4'h4
`define PSS_REG_CTRL    4'h8
`define PSS_CTRL_RESET  8'h01
`define PSS_CTRL_RUN    0
`define PSS_STAT_OVF    4

`endif

// ### logic/pss_pkg.sv
// ---------------------------------------------------------------
// Types shared by the sequencer and its bench.
// ---------------------------------------------------------------
package pss_pkg;

	// Instruction phases of one instruction cycle.
	typedef enum logic [1:0] {
		PH_T1 = 2'b00,
		PH_T2 = 2'b01,
		PH_T3 = 2'b10,
		PH_T4 = 2'b11
	} pss_phase_t;

	// Flow class that the execute unit reports for its instruction.
	typedef enum logic [2:0] {
		OP_SEQ   = 3'b000,
		OP_JUMP  = 3'b001,
		OP_CALL  = 3'b010,
		OP_RET   = 3'b011,
		OP_INTERRUPT_RETURN_INSTR  = 3'b100,
		OP_SKIP  = 3'b101
	} pss_op_t;

	// Execute unit command: flow class and full target address.
	typedef struct packed {
		pss_op_t     op;
		logic [11:0] target;
	} pss_exec_cmd_t;

endpackage

// ### logic/pss_sequencer.sv
// Design decisions made here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "pss_regs.svh"

module pss_sequencer
	import pss_pkg::*;
#(
	parameter int          STACK_DEPTH = `PSS_STACK_DEPTH,
	parameter logic [11:0] INT_VECTOR  = `PSS_INT_VECTOR
) (
	input  wire logic          REF_CLK_IN,
	input  wire logic          RST_N_IN,
	input  wire logic          WB_CYC_IN,
	input  wire logic          WB_STB_IN,
	input  wire logic          WB_WE_IN,
	input  wire logic [3:0]    WB_ADR_IN,
	input  wire logic [3:0]    WB_SEL_IN,
	input  wire logic [31:0]   WB_DAT_IN,
	output logic      [31:0]   WB_DAT_OUT,
	output logic               WB_ACK_OUT,
	output logic      [11:0]   PM_ADDR_OUT,
	output logic               PM_RD_OUT,
	input  wire logic [15:0]   PM_DATA_IN,
	input  wire pss_exec_cmd_t EXEC_CMD_IN,
	output logic      [15:0]   EXEC_INSTR_OUT,
	output logic               EXEC_VALID_OUT,
	output logic      [3:0]    PHASE_OUT,
	input  wire logic          INT_REQ_IN,
	output logic               INT_ACK_OUT,
	output logic               STACK_FULL_OUT
);

	// ---------------------------------------------------------------
	// Local sizes.
	// ---------------------------------------------------------------
	// The ring stack needs a power-of-two depth so the pointer wraps.
	localparam int SP_W = $clog2(STACK_DEPTH);
	localparam logic [SP_W:0] DEPTH_C = (SP_W+1)'(STACK_DEPTH);

	// ---------------------------------------------------------------
	// Reset release.
	// ---------------------------------------------------------------
	logic [1:0] rst_sync_reg;       // Release synchroniser.
	logic       rst_n;              // Synchronised reset, active low.

	// Reset asserts at once and releases after two clock edges.
	always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	// ---------------------------------------------------------------
	// State.
	// ---------------------------------------------------------------
	pss_phase_t  phase_reg;                    // Current phase.
	logic [3:0]  phase_oh_reg;                 // One-hot copy for the pins.
	logic [11:0] pc_reg;                       // Address being fetched.
	logic [15:0] exec_ir_reg;                  // Instruction in execute.
	logic        exec_valid_reg;               // Low during a dummy cycle.
	logic [11:0] stack_mem [STACK_DEPTH];      // Saved return addresses.
	logic [SP_W-1:0] sp_reg;                   // Next free slot.
	logic [SP_W:0]   count_reg;                // Occupied levels.
	logic        pcl_pend_reg;                 // Low byte write waiting.
	logic [7:0]  pcl_data_reg;                 // Byte to be written.
	logic        int_pend_reg;                 // Recorded interrupt request.
	logic        int_ack_reg;                  // Acknowledge pulse.
	logic        ovf_reg;                      // Sticky overflow flag.
	logic [7:0]  ctrl_reg;                     // Control register.
	logic        ack_reg;                      // Bus acknowledge.
	logic [31:0] rdata_reg;                    // Bus read data.

	// ---------------------------------------------------------------
	// Boundary decisions.
	// ---------------------------------------------------------------
	logic        run;                          // Sequencer enabled.
	logic        bnd;                          // Last phase of a cycle.
	pss_op_t     op;                           // Flow class in execute.
	logic        take_ctl;                     // Control transfer taken.
	logic        take_pcl;                     // Low byte jump taken.
	logic        take_int;                     // Interrupt acknowledged.
	logic        push;                         // Stack push.
	logic        pop;                          // Stack pop.
	logic        full;                         // All levels in use.
	logic [11:0] top;                          // Most recent saved address.
	logic [11:0] pc_next;                      // Address for the next fetch.
	logic        wb_req;                       // New bus request.

	assign run  = ctrl_reg[`PSS_CTRL_RUN];
	assign bnd  = run && (phase_reg == PH_T4);
	assign full = (count_reg == DEPTH_C);
	assign top  = stack_mem[sp_reg - 1'b1];

	// A flushed instruction carries no flow class at all.
	assign op       = exec_valid_reg ? EXEC_CMD_IN.op : OP_SEQ;
	assign take_ctl = (op != OP_SEQ);
	assign take_pcl = !take_ctl && pcl_pend_reg;
	// A full stack holds the request until a return frees a level.
	assign take_int = !take_ctl && !take_pcl && int_pend_reg && !full;
	assign push     = bnd && ((op == OP_CALL) || take_int);
	assign pop      = bnd && ((op == OP_RET) || (op == OP_INTERRUPT_RETURN_INSTR));

	// Picks where the next fetch goes.
	always_comb begin
		case (op)
			OP_JUMP, OP_CALL: begin
				pc_next = EXEC_CMD_IN.target;
			end
			OP_RET, OP_INTERRUPT_RETURN_INSTR: begin
				pc_next = top;
			end
			default: begin
				if (take_pcl) begin
					// Only the low byte moves, so the jump stays in its page.
					pc_next = {pc_reg[11:`PSS_PAGE_W], pcl_data_reg};
				end else if (take_int) begin
					pc_next = INT_VECTOR;
				end else begin
					// A true skip also lands here: the fetch moves past the
					// discarded word.
					pc_next = pc_reg + 12'h001;
				end
			end
		endcase
	end

	// ---------------------------------------------------------------
	// Phase generator.
	// ---------------------------------------------------------------
	// Four non-overlapping phases; clearing run freezes the core.
	always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			phase_reg    <= PH_T1;
			phase_oh_reg <= 4'h1;
		end else if (run) begin
			case (phase_reg)
				PH_T1: begin
					phase_reg    <= PH_T2;
					phase_oh_reg <= 4'h2;
				end
				PH_T2: begin
					phase_reg    <= PH_T3;
					phase_oh_reg <= 4'h4;
				end
				PH_T3: begin
					phase_reg    <= PH_T4;
					phase_oh_reg <= 4'h8;
				end
				default: begin
					phase_reg    <= PH_T1;
					phase_oh_reg <= 4'h1;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Program counter and pipeline.
	// ---------------------------------------------------------------
	// The counter moves at the edge that opens phase one; the word
	// fetched during this cycle moves to execute at the same edge, so
	// fetch and execute overlap.
	always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			pc_reg         <= `PSS_RESET_PC;
			exec_ir_reg    <= 16'h0000;
			exec_valid_reg <= 1'b0;
		end else if (bnd) begin
			pc_reg         <= pc_next;
			exec_ir_reg    <= PM_DATA_IN;
			// Any redirect turns the prefetched word into a dummy cycle.
			exec_valid_reg <= !(take_ctl || take_pcl || take_int);
		end
	end

	// ---------------------------------------------------------------
	// Return stack.
	// ---------------------------------------------------------------
	// A ring of slots: a push onto a full stack overwrites the oldest
	// entry and keeps the rest. The pointer is not on the bus.
	always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			sp_reg    <= '0;
			count_reg <= '0;
		end else if (push) begin
			sp_reg <= sp_reg + 1'b1;
			if (!full) begin
				count_reg <= count_reg + 1'b1;
			end
		end else if (pop) begin
			sp_reg <= sp_reg - 1'b1;
			if (count_reg != '0) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end

	// The slots hold only counter values and have no reset. The saved
	// address is the word that was being fetched, the one after the call.
	always_ff @(posedge REF_CLK_IN) begin
		if (push) begin
			stack_mem[sp_reg] <= pc_reg;
		end
	end

	// ---------------------------------------------------------------
	// Interrupt request and acknowledge.
	// ---------------------------------------------------------------
	// A new request in the acknowledge cycle keeps the flag set.
	always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			int_pend_reg <= 1'b0;
			int_ack_reg  <= 1'b0;
		end else begin
			int_pend_reg <= INT_REQ_IN || (int_pend_reg && !(bnd && take_int));
			int_ack_reg  <= bnd && take_int;
		end
	end

	// ---------------------------------------------------------------
	// Wishbone slave.
	// ---------------------------------------------------------------
	assign wb_req = WB_CYC_IN && WB_STB_IN && !ack_reg;

	// Every access, mapped or not, is acknowledged one cycle after it.
	always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			ack_reg   <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= wb_req;
			case (WB_ADR_IN)
				`PSS_REG_PCL: begin
					rdata_reg <= {24'h000000, pc_reg[7:0]};
				end
				`PSS_REG_STAT: begin
					rdata_reg <= {23'h000000, (4'(count_reg)), ovf_reg, 1'b0, full, phase_reg};
				end
				`PSS_REG_CTRL: begin
					rdata_reg <= {24'h000000, ctrl_reg};
				end
				default: begin
					rdata_reg <= 32'h0000_0000;
				end
			endcase
		end
	end

	// Control register and sticky overflow; a new overflow wins over a
	// clear in the same cycle.
	always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= `PSS_CTRL_RESET;
			ovf_reg  <= 1'b0;
		end else begin
			if (wb_req && WB_WE_IN && WB_SEL_IN[0] && (WB_ADR_IN == `PSS_REG_CTRL)) begin
				ctrl_reg <= WB_DAT_IN[7:0];
			end
			if (push && full) begin
				ovf_reg <= 1'b1;
			end else if (wb_req && WB_WE_IN && WB_SEL_IN[0] && (WB_ADR_IN == `PSS_REG_STAT)
				&& WB_DAT_IN[`PSS_STAT_OVF]) begin
				ovf_reg <= 1'b0;
			end
		end
	end

	// A low byte write waits for the next boundary; a later write
	// replaces the byte and wins over the clear.
	always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			pcl_pend_reg <= 1'b0;
			pcl_data_reg <= 8'h00;
		end else if (wb_req && WB_WE_IN && WB_SEL_IN[0] && (WB_ADR_IN == `PSS_REG_PCL)) begin
			pcl_pend_reg <= 1'b1;
			pcl_data_reg <= WB_DAT_IN[7:0];
		end else if (bnd && take_pcl) begin
			pcl_pend_reg <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Outputs.
	// ---------------------------------------------------------------
	assign WB_ACK_OUT     = ack_reg;
	assign WB_DAT_OUT     = rdata_reg;
	assign PM_ADDR_OUT    = pc_reg;
	assign PM_RD_OUT      = run && (phase_reg == PH_T1);
	assign EXEC_INSTR_OUT = exec_ir_reg;
	assign EXEC_VALID_OUT = exec_valid_reg;
	assign PHASE_OUT      = phase_oh_reg;
	assign INT_ACK_OUT    = int_ack_reg;
	assign STACK_FULL_OUT = full;

	// ---------------------------------------------------------------
	// Assertions.
	// ---------------------------------------------------------------
	a_phase_onehot: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n)
		$onehot(PHASE_OUT) && (PHASE_OUT == (4'h1 << phase_reg)))
		else $error("Phase outputs not one-hot.");

	a_phase_wrap: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n)
		(bnd && $stable(ctrl_reg)) |=> (PHASE_OUT == 4'h1) ##1 (PHASE_OUT == 4'h2 || !run))
		else $error("Phase sequence broken.");

	a_pc_increment: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n)
		(bnd && !take_ctl && !take_pcl && !take_int) |=> (pc_reg == $past(pc_reg) + 12'h001)
			&& EXEC_VALID_OUT)
		else $error("Counter did not step by one.");

	a_jump_flush: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n)
		(bnd && (op == OP_JUMP || op == OP_CALL)) |=> !EXEC_VALID_OUT
			&& (PM_ADDR_OUT == $past(EXEC_CMD_IN.target)))
		else $error("Jump not flushed or wrong target.");

	a_skip_dummy: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n)
		(bnd && op == OP_SKIP) |=> !EXEC_VALID_OUT && (pc_reg == $past(pc_reg) + 12'h001))
		else $error("Skip did not insert a dummy cycle.");

	a_pcl_page: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n)
		(bnd && take_pcl) |=> (pc_reg[11:8] == $past(pc_reg[11:8]))
			&& (pc_reg[7:0] == $past(pcl_data_reg)) && !EXEC_VALID_OUT)
		else $error("Low byte jump left its page.");

	a_call_return: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n)
		(push && !pop) |=> (top == $past(pc_reg)))
		else $error("Push saved the wrong address.");

	a_full_inhibit: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n)
		(bnd && full && !pop) |=> !INT_ACK_OUT)
		else $error("Interrupt acknowledged on a full stack.");

	a_overflow_keep: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n)
		(push && full) |=> full && ovf_reg)
		else $error("Overflow changed the depth.");

	a_reset_start: assert property (@(posedge REF_CLK_IN)
		$rose(rst_n) |-> (pc_reg == `PSS_RESET_PC) && (count_reg == '0) && !EXEC_VALID_OUT)
		else $error("Reset state wrong.");

endmodule // pss_sequencer

// ### bench/pss_prog_mem.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// Program memory model: each word is a marker over its address.
// ------------------------------------------------------------
module pss_prog_mem (
	input  wire logic        clk_in,
	input  wire logic [11:0] addr_in,
	input  wire logic        rd_in,
	input  wire logic [1:0]  lat_in,
	output logic      [15:0] data_out
);
	logic [11:0] addr_reg = 12'h000; // Address caught at the fetch strobe.
	logic [1:0]  age_reg  = 2'h3;    // Cycles since the strobe, saturating.

	// Catch the address in the fetch phase and count the access time.
	always_ff @(posedge clk_in) begin
		if (rd_in) begin
			addr_reg <= addr_in;
			age_reg  <= 2'h0;
		end else if (age_reg != 2'h3) begin
			age_reg <= age_reg + 2'h1;
		end
	end

	// Before the access time has run the bus shows the inverse word, so an early sample fails.
	assign data_out = (age_reg >= lat_in) ? {4'h5, addr_reg} : ~{4'h5, addr_reg};
endmodule // pss_prog_mem

// ### bench/program_sequencer_stack_test.sv
`timescale 1ns/1ps
`include "pss_regs.svh"

module program_sequencer_stack_test
	import pss_pkg::*;
;

	// ------------------------------------------------------------
	// Signals and expected state.
	// ------------------------------------------------------------
	logic          clk      = 1'b0;
	logic          rst_n    = 1'b1; // Falls at time zero so the clear fires before the first edge.
	logic          cyc      = 1'b0;
	logic          stb      = 1'b0;
	logic          we       = 1'b0;
	logic          irq      = 1'b0;
	logic [3:0]    adr      = 4'h0;
	logic [31:0]   wdat     = 32'h0;
	logic [1:0]    lat      = 2'h2;
	pss_exec_cmd_t cmd      = '{OP_SEQ, 12'h000};
	logic [12:0]   pcl_pend = 13'h0; // Bit 12 marks a short jump not yet taken.
	logic          int_pend = 1'b0;  // Interrupt raised but not yet served.
	logic [11:0]   exp_pc   = 12'h000;
	logic [11:0]   stk[$];           // Expected saved addresses, newest last.
	logic [31:0]   rdat, q;
	logic [11:0]   pma;
	logic [15:0]   pmd, ins;
	logic [3:0]    ph, p;
	logic          ack, rd, vld, iack, full;
	int            acks = 0, exp_acks = 0, failures = 0, comparisons = 0;

	always #12.5 clk = ~clk; // 40 MHz.
	always @(posedge clk) if (iack === 1'b1) acks++;

	pss_sequencer pss_sequencer_i (.REF_CLK_IN(clk), .RST_N_IN(rst_n), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
		.WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(4'hF), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat),
		.WB_ACK_OUT(ack), .PM_ADDR_OUT(pma), .PM_RD_OUT(rd), .PM_DATA_IN(pmd), .EXEC_CMD_IN(cmd),
		.EXEC_INSTR_OUT(ins), .EXEC_VALID_OUT(vld), .PHASE_OUT(ph), .INT_REQ_IN(irq),
		.INT_ACK_OUT(iack), .STACK_FULL_OUT(full));
	pss_prog_mem pss_prog_mem_i (.clk_in(clk), .addr_in(pma), .rd_in(rd), .lat_in(lat), .data_out(pmd));

	// ------------------------------------------------------------
	// Checks, bus cycles and instruction boundaries.
	// ------------------------------------------------------------
	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t %s: got %h, expected %h", $time, what, got, exp);
		end
	endtask

	task automatic chk_flag(input logic got, input logic exp, input string what);
		chk_val({31'h0, got}, {31'h0, exp}, what);
	endtask

	// One classic cycle; holds everything until ack is seen at a rising edge.
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (n >= 20) failures++;
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	// Presents a flow class for the next boundary; the model below judges it.
	task automatic step(input pss_op_t op, input logic [11:0] t);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ph !== 4'b0100 && n < 20);
		if (n >= 20) failures++;
		cmd <= '{op, t};
		@(posedge clk);
		cmd <= '{OP_SEQ, 12'h000};
		#2;
	endtask

	// Every boundary is modelled, also those the scenarios leave to run freely.
	always @(posedge clk) begin : model
		logic [11:0] a, np;
		logic        nv;
		pss_op_t     e;
		if (rst_n === 1'b1 && ph === 4'b1000) begin
			a  = pma;
			e  = (vld === 1'b1) ? cmd.op : OP_SEQ;
			np = a + 12'h001;
			nv = 1'b0;
			chk_val(acks, exp_acks, "interrupt acks");
			case (e)
				OP_JUMP: np = cmd.target;
				OP_CALL: begin
					if (stk.size() == `PSS_STACK_DEPTH) void'(stk.pop_front());
					stk.push_back(a);
					np = cmd.target;
				end
				OP_RET, OP_INTERRUPT_RETURN_INSTR: np = stk.pop_back();
				OP_SKIP: np = a + 12'h001;
				default: begin
					if (pcl_pend[12]) begin
						np       = {a[11:8], pcl_pend[7:0]};
						pcl_pend = 13'h0;
					end else if (int_pend && stk.size() < `PSS_STACK_DEPTH) begin
						stk.push_back(a);
						np       = `PSS_INT_VECTOR;
						int_pend = 1'b0;
						exp_acks++;
					end else begin
						nv = 1'b1;
					end
				end
			endcase
			exp_pc = np;
			#1;
			chk_val(pma, np, "fetch address");
			chk_flag(vld, nv, "execute valid");
			if (nv) chk_val(ins, {4'h5, a}, "execute word");
			chk_flag(full, stk.size() == `PSS_STACK_DEPTH, "stack full");
		end
	end

	// ------------------------------------------------------------
	// Verdict, watchdog and scenarios.
	// ------------------------------------------------------------
	task automatic complete_run();
		$display("Counts: %0d comparisons, %0d mismatches", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		#(4000 * 25);
		failures++;
		complete_run();
	end

	initial begin
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		// The internal copy of reset lets go two edges after the pin.
		repeat (2) @(posedge clk);
		#1;
		chk_val(pma, 12'h000, "reset address");
		chk_flag(vld, 1'b0, "reset valid");
		p = ph;
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			#1;
			chk_val(ph, {p[2:0], p[3]}, "phase order");
			chk_flag(rd, ph[0], "fetch strobe");
			p = ph;
		end
		wb(1'b0, `PSS_REG_PCL, 32'h0);
		chk_val(q[7:0], exp_pc[7:0], "pc low read");
		wb(1'b0, `PSS_REG_STAT, 32'h0);
		chk_val({q[8:5], q[2]}, 5'h00, "empty stack");
		wb(1'b0, 4'hC, 32'h0);
		chk_val(q, 32'h0, "unmapped read");
		$display("test reset done");
		repeat (3) step(OP_SEQ, 12'h000);
		lat <= 2'h0;
		step(OP_JUMP, 12'h3F0);
		repeat (2) step(OP_SEQ, 12'h000);
		step(OP_SKIP, 12'h000);
		repeat (2) step(OP_SEQ, 12'h000);
		$display("test flow done");
		wb(1'b1, `PSS_REG_PCL, 32'h42);
		pcl_pend = 13'h1042;
		repeat (2) step(OP_SEQ, 12'h000);
		wb(1'b0, `PSS_REG_PCL, 32'h0);
		chk_val(q[7:0], exp_pc[7:0], "pc low after jump");
		$display("test short jump done");
		for (int i = 0; i < 9; i++) begin
			step(OP_SEQ, 12'h000);
			step(OP_CALL, {4'h1, i[3:0], 4'h0});
		end
		wb(1'b0, `PSS_REG_STAT, 32'h0);
		chk_val({q[8:5], q[4], q[2]}, 6'h23, "full status");
		int_pend = 1'b1;
		irq     <= 1'b1;
		@(posedge clk);
		irq <= 1'b0;
		step(OP_SEQ, 12'h000);
		step(OP_RET, 12'h000);
		repeat (2) step(OP_SEQ, 12'h000);
		step(OP_INTERRUPT_RETURN_INSTR, 12'h000);
		repeat (7) begin
			step(OP_SEQ, 12'h000);
			step(OP_RET, 12'h000);
		end
		wb(1'b1, `PSS_REG_STAT, 32'h10);
		wb(1'b0, `PSS_REG_STAT, 32'h0);
		chk_val({q[8:5], q[4], q[2]}, 6'h00, "stack drained");
		$display("test stack done");
		// Start right after a boundary so the freeze lands in phase three.
		step(OP_SEQ, 12'h000);
		wb(1'b1, `PSS_REG_CTRL, 32'h0);
		p = ph;
		repeat (6) @(posedge clk);
		#1;
		chk_val(ph, p, "frozen phase");
		chk_val(pma, exp_pc, "frozen address");
		wb(1'b0, `PSS_REG_CTRL, 32'h0);
		chk_val(q, 32'h0, "run cleared");
		wb(1'b1, `PSS_REG_CTRL, 32'h1);
		$display("test run control done");
		repeat (8) @(posedge clk);
		chk_val(acks, exp_acks, "final acks");
		complete_run();
	end
endmodule // program_sequencer_stack_test
